// ==== src/jump_register_cfg.svh ====
// Purpose: constants for the register-indirect jump decoder
// Assumes: 32-bit instruction words, releases coded as small integers
// Notes: definitions only
`ifndef JUMP_REGISTER_CFG_SVH
`define JUMP_REGISTER_CFG_SVH

// instruction field positions
`define OPC_HI 31
`define OPC_LO 26
`define SRC_HI 25
`define SRC_LO 21
`define ZERO_HI 20
`define ZERO_LO 11
`define RD_HI 15
`define RD_LO 11
`define RT_HI 20
`define RT_LO 16
`define HINT_HI 10
`define HINT_LO 6
`define BARRIER_BIT 10
`define FUNC_HI 5
`define FUNC_LO 0

// encodings
`define OPC_SPECIAL 6'h00
`define FUNC_JUMP_OLD 6'h08
`define FUNC_JUMP_LINK 6'h09
`define ZERO_FIELD10 10'h000
`define ZERO_FIELD5 5'h00
`define HINT_DEFAULT 5'h00

// architecture release codes on the release input
`define REL_FIRST 3'h1
`define REL_SECOND 3'h2
`define REL_NEWER 3'h6

`endif

// ==== src/jump_register_pkg.sv ====
// Purpose: types shared by the jump decoder files
// Assumes: nothing beyond the cfg header
// Notes: the state struct is the whole of the top's storage
package jump_register_pkg;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SLOT
    } jump_state_t;

    typedef struct packed {
        jump_state_t state;
        logic [63:0] target;
        logic isa_next;
        logic isa_load;
        logic addr_err;
        logic barrier;
        logic instr_set_select;
    } jump_regs_t;

endpackage : jump_register_pkg

// ==== src/jump_target_former.sv ====
// Purpose: forms next fetch address, mode bit and alignment fault
// Assumes: source register value read at jump issue
// Notes: pure combinational, no state
`timescale 1ns/1ns
`default_nettype none

module jump_target_former #(
    parameter int GPRLEN = 64
) (
    input wire logic [GPRLEN-1:0] src_value, // general_register contents
    input wire logic compressed_cfg, // compressed set present
    input wire logic code_compress_cfg, // code compression present
    output logic [GPRLEN-1:0] next_pc, // address to fetch after slot
    output logic isa_bit, // new instr_set_select value
    output logic isa_update, // mode bit is to be loaded
    output logic addr_err // target fetch must fault
);

    logic direct;

    // direct path only when neither indicator is set
    assign direct = !compressed_cfg && !code_compress_cfg;

    // direct path keeps the full value; else bit 0 is the mode bit
    always_comb
    begin
        if (direct)
        begin
            next_pc = src_value;
            isa_bit = 1'b0;
            isa_update = 1'b0;
            addr_err = |src_value[1:0];
        end
        else
        begin
            next_pc = {src_value[GPRLEN-1:1], 1'b0};
            isa_bit = src_value[0];
            isa_update = 1'b1;
            addr_err = !src_value[0] && src_value[1];
        end
    end

endmodule : jump_target_former

`default_nettype wire

// ==== src/jump_register_decode_execute.sv ====
// Purpose: decode and execute the register jump and its barrier form
// Assumes: one instruction offered per cycle, register value same cycle
// Notes: redirect fires when the delay slot instruction issues
`timescale 1ns/1ns
`default_nettype none
`include "jump_register_cfg.svh"

module jump_register_decode_execute #(
    parameter int GPRLEN = 64
) (
    input wire logic CLK, // core clock
    input wire logic NRST, // async reset, active low
    input wire logic CE, // clock enable, freezes state when low
    input wire logic INSTR_VALID, // an instruction issues this cycle
    input wire logic [31:0] INSTR, // instruction word
    input wire logic INSTR_IS_CTI, // other decoders flag a transfer op
    input wire logic [GPRLEN-1:0] SRC_VALUE, // general_register read
    input wire logic [2:0] ARCH_RELEASE, // architecture release code
    input wire logic COMPRESSED_SET_SUPPORT_CFG, // compressed set present
    input wire logic CODE_COMPRESS_SUPPORT_CFG, // compression present
    output logic [4:0] SOURCE_REG_FIELD, // register to read
    output logic JUMP_HIT, // a register jump decodes
    output logic BARRIER_HIT, // the barrier form decodes
    output logic RESERVED_INSTR, // reserved instruction exception
    output logic SLOT_PENDING, // waiting for the delay slot
    output logic REDIRECT_VALID, // fetch must go to REDIRECT_PC
    output logic [GPRLEN-1:0] REDIRECT_PC, // target address
    output logic TARGET_ADDR_ERROR, // target fetch raises address error
    output logic HAZARD_CLEAR, // clear hazards before target fetch
    output logic INSTR_SET_SELECT // current instr_set_select
);
    import jump_register_pkg::*;

    jump_regs_t r;
    jump_regs_t next_r;

    logic is_special;
    logic old_form;
    logic new_form;
    logic newer_rel;
    logic hint_ok;
    logic decode_ok;
    logic decode_bad;
    logic barrier_dec;
    logic [GPRLEN-1:0] formed_pc;
    logic formed_isa;
    logic formed_load;
    logic formed_err;
    logic slot_issue;
    logic slot_cti_fault;

    // target forming, shared by both encodings
    jump_target_former #(
        .GPRLEN(GPRLEN)
    ) u_former (
        .src_value(SRC_VALUE),
        .compressed_cfg(COMPRESSED_SET_SUPPORT_CFG),
        .code_compress_cfg(CODE_COMPRESS_SUPPORT_CFG),
        .next_pc(formed_pc),
        .isa_bit(formed_isa),
        .isa_update(formed_load),
        .addr_err(formed_err)
    );

    // field decode
    assign SOURCE_REG_FIELD = INSTR[`SRC_HI:`SRC_LO];
    assign is_special = INSTR[`OPC_HI:`OPC_LO] == `OPC_SPECIAL;
    assign newer_rel = ARCH_RELEASE == `REL_NEWER;

    // older form: bits 20..11 must be zero
    assign old_form = is_special
        && INSTR[`FUNC_HI:`FUNC_LO] == `FUNC_JUMP_OLD
        && INSTR[`ZERO_HI:`ZERO_LO] == `ZERO_FIELD10;

    // newer form: link jump whose destination field is zero
    assign new_form = is_special
        && INSTR[`FUNC_HI:`FUNC_LO] == `FUNC_JUMP_LINK
        && INSTR[`RT_HI:`RT_LO] == `ZERO_FIELD5
        && INSTR[`RD_HI:`RD_LO] == `ZERO_FIELD5;

    // first release allows hint zero only; later ones any hint
    always_comb
    begin
        if (ARCH_RELEASE == `REL_FIRST)
        begin
            hint_ok = INSTR[`HINT_HI:`HINT_LO] == `HINT_DEFAULT;
            barrier_dec = 1'b0;
        end
        else
        begin
            hint_ok = 1'b1;
            barrier_dec = INSTR[`BARRIER_BIT];
        end
    end

    // the old dedicated form is gone under the newer release
    always_comb
    begin
        if (newer_rel)
        begin
            decode_ok = new_form && hint_ok;
            decode_bad = old_form;
        end
        else
        begin
            decode_ok = old_form && hint_ok;
            decode_bad = old_form && !hint_ok;
        end
    end

    assign JUMP_HIT = INSTR_VALID && decode_ok && r.state == ST_IDLE;
    assign BARRIER_HIT = JUMP_HIT && barrier_dec;

    // the delay slot instruction issues while a jump waits
    assign slot_issue = INSTR_VALID && r.state == ST_SLOT;

    // a transfer op in the slot, our jump included, is reserved under
    // the newer release; older releases leave it unpredictable and
    // this block then simply treats it as the slot instruction
    assign slot_cti_fault = slot_issue && newer_rel
        && (INSTR_IS_CTI || decode_ok || decode_bad);

    // reserved when mis-encoded in idle or faulting in the slot
    assign RESERVED_INSTR = (INSTR_VALID && r.state == ST_IDLE
        && decode_bad) || slot_cti_fault;

    // redirect once the slot instruction has issued cleanly;
    // the jump itself reports no fault, the fetch of the target does
    assign REDIRECT_VALID = slot_issue && !slot_cti_fault;
    assign REDIRECT_PC = r.target;
    assign TARGET_ADDR_ERROR = REDIRECT_VALID && r.addr_err;

    // barrier released with the redirect: hazards from before the
    // jump are cleared; the slot instruction is already issuing, so
    // its own hazards are not promised to be cleared
    assign HAZARD_CLEAR = REDIRECT_VALID && r.barrier;

    assign SLOT_PENDING = r.state == ST_SLOT;
    assign INSTR_SET_SELECT = r.instr_set_select;

    // next state: capture target at issue, commit after the slot
    always_comb
    begin
        next_r = r;
        case (r.state)
            ST_IDLE:
            begin
                if (JUMP_HIT)
                begin
                    next_r.state = ST_SLOT;
                    next_r.target = formed_pc;
                    next_r.isa_next = formed_isa;
                    next_r.isa_load = formed_load;
                    next_r.addr_err = formed_err;
                    next_r.barrier = barrier_dec;
                end
            end
            ST_SLOT:
            begin
                if (slot_issue)
                begin
                    next_r.state = ST_IDLE;
                    // mode bit changes only when the jump completes
                    if (REDIRECT_VALID && r.isa_load)
                    begin
                        next_r.instr_set_select = r.isa_next;
                    end
                end
            end
            default:
            begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    // state register; CE low holds everything
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            r <= '0;
        end
        else if (CE)
        begin
            r <= next_r;
        end
    end

endmodule : jump_register_decode_execute

`default_nettype wire

// ==== dv/fetch_model.sv ====
// Purpose: fetch side that follows decoder redirects
// Assumes: word-sized sequential fetch between redirects
// Notes: a bad target traps here, at its fetch
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
    input wire logic clk, nrst, ce, // core clock, reset, enable
    input wire logic redirect, fault, // go to target, target faults
    input wire logic [63:0] target, // next fetch address
    output logic [63:0] pc, // address being fetched
    output logic trap // address error taken at fetch
);
    // the trap belongs to the target fetch, never to the jump itself
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            {pc, trap} <= 65'h0;
        else if (ce)
            {pc, trap} <= redirect ? {target, fault} : {pc + 64'h4, 1'b0};
endmodule : fetch_model
`default_nettype wire

// ==== dv/jump_decode_sva.sv ====
// Purpose: port checks for the register jump decoder
// Assumes: config inputs hold while a jump waits
// Notes: bound to every decoder instance
`timescale 1ns/1ns
`default_nettype none
module jump_decode_checker #(
    parameter int GPRLEN = 64
) (
    input wire logic CLK, NRST, CE, INSTR_VALID, INSTR_IS_CTI, // core
    input wire logic [31:0] INSTR, // word
    input wire logic [GPRLEN-1:0] SRC_VALUE, REDIRECT_PC, // addresses
    input wire logic [2:0] ARCH_RELEASE, // release
    input wire logic COMPRESSED_SET_SUPPORT_CFG, CODE_COMPRESS_SUPPORT_CFG,
    input wire logic JUMP_HIT, RESERVED_INSTR, SLOT_PENDING, // decode
    input wire logic REDIRECT_VALID, TARGET_ADDR_ERROR, HAZARD_CLEAR,
    input wire logic INSTR_SET_SELECT // mode
);
    wire logic cmp = COMPRESSED_SET_SUPPORT_CFG | CODE_COMPRESS_SUPPORT_CFG;
    logic lsb;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // mode bit offered at issue; only one jump is ever in flight
    always_ff @(posedge CLK or negedge NRST)
        if (!NRST)
            lsb <= 1'b0;
        else if (JUMP_HIT && CE)
            lsb <= SRC_VALUE[0];
    a_slot_wait: assert property (JUMP_HIT && CE |=> SLOT_PENDING)
        else $error("jump not followed by slot wait");
    a_pc_full: assert property (JUMP_HIT && CE && !cmp |=>
        REDIRECT_PC == $past(SRC_VALUE)) else $error("target not kept whole");
    a_pc_clear: assert property (JUMP_HIT && CE && cmp |=>
        !REDIRECT_PC[0] && (REDIRECT_PC | 'h1) == ($past(SRC_VALUE) | 'h1))
        else $error("target bit 0 not cleared");
    a_direct_err: assert property (REDIRECT_VALID && !cmp |->
        TARGET_ADDR_ERROR == (REDIRECT_PC[1:0] != 2'h0))
        else $error("direct alignment fault wrong");
    a_comp_err: assert property (REDIRECT_VALID && cmp |->
        TARGET_ADDR_ERROR == (!lsb && REDIRECT_PC[1]))
        else $error("compressed alignment fault wrong");
    a_mode_load: assert property (REDIRECT_VALID && CE && cmp |=>
        INSTR_SET_SELECT == lsb) else $error("mode bit not loaded");
    a_mode_keep: assert property (REDIRECT_VALID && CE && !cmp |=>
        $stable(INSTR_SET_SELECT)) else $error("mode bit changed");
    a_slot_reserved: assert property (SLOT_PENDING && INSTR_VALID &&
        INSTR_IS_CTI && ARCH_RELEASE == 3'h6 |-> RESERVED_INSTR &&
        !REDIRECT_VALID) else $error("transfer in slot not refused");
    a_hint_first: assert property (JUMP_HIT && ARCH_RELEASE == 3'h1 |->
        INSTR[10:6] == 5'h00) else $error("first release took a hint");
    a_hazard_redir: assert property (HAZARD_CLEAR |-> REDIRECT_VALID)
        else $error("hazard release without redirect");
    c_barrier: cover property (HAZARD_CLEAR);
    c_fault: cover property (TARGET_ADDR_ERROR);
    c_slot_refused: cover property (RESERVED_INSTR && SLOT_PENDING);
endmodule : jump_decode_checker
bind jump_register_decode_execute jump_decode_checker #(.GPRLEN(GPRLEN))
    jump_decode_checker_inst (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: directed tests of the register jump decoder
// Assumes: slot word is a plain op unless a test says otherwise
// Notes: expectations are rebuilt from the offered target
`timescale 1ns/1ns
`default_nettype none
`include "jump_register_cfg.svh"
module tb_top;
    logic CLK, NRST, CE, INSTR_VALID, INSTR_IS_CTI;
    logic COMPRESSED_SET_SUPPORT_CFG, CODE_COMPRESS_SUPPORT_CFG;
    logic [31:0] INSTR;
    logic [63:0] SRC_VALUE, REDIRECT_PC, fetch_pc;
    logic [2:0] ARCH_RELEASE;
    logic [4:0] SOURCE_REG_FIELD;
    logic JUMP_HIT, BARRIER_HIT, RESERVED_INSTR, SLOT_PENDING, fetch_fault;
    logic REDIRECT_VALID, TARGET_ADDR_ERROR, HAZARD_CLEAR, INSTR_SET_SELECT;
    int num_errors, compares, cycles;
    logic mode_exp; // mode bit the rules predict
    jump_register_decode_execute jump_register_decode_execute_inst (.*);
    fetch_model fetch_model_inst (.clk(CLK), .nrst(NRST), .ce(CE),
        .redirect(REDIRECT_VALID), .fault(TARGET_ADDR_ERROR),
        .target(REDIRECT_PC), .pc(fetch_pc), .trap(fetch_fault));
    // 125 MHz core clock
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // a stuck run is cut off well past the roughly 50 cycles needed
    always @(posedge CLK)
        if (++cycles == 2000)
        begin
            num_errors++;
            complete_run();
        end
    task automatic check(input logic [63:0] seen, exp);
        compares++;
        num_errors += int'(seen !== exp);
        if (seen !== exp)
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    endtask : check
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // one jump, its slot, then an idle cycle to see the mode bit land
    task automatic run(input logic [31:0] w, input logic [63:0] v,
        input logic [2:0] rel, input logic [1:0] cfg, input logic hit, control_transfer_op);
        logic on, bad, e, hb, m;
        logic [63:0] t;
        on = |cfg;
        t = on ? {v[63:1], 1'b0} : v;
        bad = control_transfer_op && rel == `REL_NEWER;
        e = on ? !v[0] && v[1] : v[1:0] != 2'h0;
        hb = w[`BARRIER_BIT] && rel != `REL_FIRST;
        m = on && hit && !bad ? v[0] : mode_exp;
        mode_exp = m;
        @(posedge CLK);
        {INSTR, SRC_VALUE, ARCH_RELEASE} <= {w, v, rel};
        {COMPRESSED_SET_SUPPORT_CFG, CODE_COMPRESS_SUPPORT_CFG} <= cfg;
        {INSTR_VALID, INSTR_IS_CTI} <= 2'b10;
        #2;
        check(JUMP_HIT, hit);
        check(SOURCE_REG_FIELD, w[25:21]);
        check(RESERVED_INSTR, !hit);
        check(BARRIER_HIT, hit && hb);
        if (hit)
        begin
            @(posedge CLK);
            {INSTR, SRC_VALUE, INSTR_IS_CTI} <= {32'h0, ~v, control_transfer_op};
            #2;
            check(SLOT_PENDING, 1'b1);
            check(REDIRECT_VALID, !bad);
            check(RESERVED_INSTR, bad);
            check(REDIRECT_PC, t);
            check(TARGET_ADDR_ERROR, !bad && e);
            check(HAZARD_CLEAR, !bad && hb);
        end
        @(posedge CLK);
        INSTR_VALID <= 1'b0;
        #2;
        check(SLOT_PENDING, 1'b0);
        check(INSTR_SET_SELECT, m);
        if (hit && !bad)
            check({fetch_fault, fetch_pc}, {e, t});
        $display("test done at %0t", $time);
    endtask : run
    initial
    begin
        {NRST, INSTR_VALID, INSTR_IS_CTI, INSTR, SRC_VALUE} = '0;
        {ARCH_RELEASE, COMPRESSED_SET_SUPPORT_CFG} = '0;
        CODE_COMPRESS_SUPPORT_CFG = 1'b0;
        CE = 1'b1;
        mode_exp = 1'b0;
        repeat (20) @(posedge CLK);
        #2;
        check(REDIRECT_PC, 64'h0);
        check({SLOT_PENDING, INSTR_SET_SELECT}, 2'h0);
        @(posedge CLK);
        NRST <= 1'b1;
        run(32'h00800008, 64'h1040, `REL_SECOND, 2'b00, 1'b1, 1'b0);
        run(32'h03E00008, 64'h1042, `REL_SECOND, 2'b00, 1'b1, 1'b0);
        run(32'h00A00008, 64'h1043, `REL_SECOND, 2'b10, 1'b1, 1'b0);
        run(32'h00C00008, 64'h1042, `REL_SECOND, 2'b01, 1'b1, 1'b0);
        run(32'h00E00408, 64'h1040, `REL_SECOND, 2'b00, 1'b1, 1'b0);
        run(32'h00E00408, 64'h1040, `REL_FIRST, 2'b00, 1'b0, 1'b0);
        run(32'h01000008, 64'h1040, `REL_NEWER, 2'b00, 1'b0, 1'b0);
        run(32'h010007C9, 64'h1041, `REL_NEWER, 2'b11, 1'b1, 1'b0);
        run(32'h01200009, 64'h1040, `REL_NEWER, 2'b00, 1'b1, 1'b1);
        run(32'h01200008, 64'h1040, `REL_SECOND, 2'b00, 1'b1, 1'b1);
        // a jump offered while the enable is low must not register
        @(posedge CLK);
        {CE, INSTR_VALID, INSTR} <= {1'b0, 1'b1, 32'h00800008};
        @(posedge CLK);
        {CE, INSTR_VALID} <= 2'b10;
        #2;
        check(SLOT_PENDING, 1'b0);
        $display("freeze test done at %0t", $time);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
